// ==== design/cmpev_edge_if.sv ====
// Interface carrying a sampled comparator level and its edge pulses
// between the input conditioner and the event logic.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface cmpev_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// ==== design/cmpev_pkg.sv ====
// Package for the comparator event control block: register map, field
// positions, reset values and encodings.
// Assumes a 32-bit APB slave with word-aligned registers.
package cmpev_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] CMPEV_CTRL_OFF   = 12'h000;
  localparam logic [11:0] CMPEV_STAT_OFF   = 12'h004;
  localparam logic [11:0] CMPEV_IRQST_OFF  = 12'h008;
  localparam logic [11:0] CMPEV_IRQMSK_OFF = 12'h00C;
  localparam logic [11:0] CMPEV_INPUT_OFF  = 12'h010;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CMPEV_EN_BIT    = 15;
  localparam int CMPEV_OE_BIT    = 14;
  localparam int CMPEV_POL_BIT   = 13;
  localparam int CMPEV_EVT_BIT   = 9;
  localparam int CMPEV_OUT_BIT   = 8;
  localparam int CMPEV_EDGE_HI   = 7;
  localparam int CMPEV_EDGE_LO   = 6;
  localparam int CMPEV_REF_BIT   = 4;
  localparam int CMPEV_CHHI_BIT  = 1;
  localparam int CMPEV_CHLO_BIT  = 0;
  localparam logic [15:0] CMPEV_CTRL_WMASK = 16'hE0D3;
  localparam logic [15:0] CMPEV_CTRL_RST   = 16'h0000;

  // Shared status fields: result bits low, event bits at 8 and up
  localparam int CMPEV_STAT_EVT_BASE = 8;
  localparam int CMPEV_UNITS         = 4;
  localparam int CMPEV_UNIT_ONE_IDX  = 0;
  localparam int CMPEV_UNIT_TWO_IDX  = 1;

  // Interrupt status/mask: bit 0 is the edge event
  localparam int CMPEV_IRQ_EVT_BIT = 0;
  localparam logic [31:0] CMPEV_ZERO32 = 32'h0000_0000;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    CMPEV_EDGE_NONE = 2'b00,
    CMPEV_EDGE_RISE = 2'b01,
    CMPEV_EDGE_FALL = 2'b10,
    CMPEV_EDGE_ANY  = 2'b11
  } cmpev_edge_type;

  typedef enum logic [1:0] {
    CMPEV_APB_IDLE   = 2'b00,
    CMPEV_APB_ACCESS = 2'b01
  } cmpev_apb_type;

endpackage

// ==== design/cmpev_sync.sv ====
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes the input is asynchronous to core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module cmpev_sync
  import cmpev_pkg::*;
(
  input  wire logic   core_clk_in,
  input  wire logic   reset_in,
  input  wire logic   async_in,
  cmpev_edge_if.src   edge_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  // First stage feeds only the second to keep metastability contained
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level only changes once stages two and three agree
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  // Edge pulses against the filtered level
  assign edge_out.level = lvl_q;
  assign edge_out.rise  = (s2_q == s3_q) && s3_q && !lvl_q;
  assign edge_out.fall  = (s2_q == s3_q) && !s3_q && lvl_q;

endmodule // cmpev_sync
`default_nettype wire

// ==== design/cmpev_top.sv ====
// Comparator event control: APB registers, polarity, pin drive, edge
// event flag, shared status and a level interrupt.
// Assumes the analog core's raw result arrives asynchronously and the
// input mux is steered from the select outputs.
`timescale 1ns/1ps
`default_nettype none

module cmpev_top
  import cmpev_pkg::*;
#(
  parameter logic [3:0] AVAIL_INPUTS = 4'hF  // Inputs bonded out
)(
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        raw_result_in,
  input  wire logic [3:0]  other_result_in,
  input  wire logic [3:0]  other_event_in,
  output logic             result_pin_out,
  output logic             result_pin_oe_out,
  output logic [1:0]       input_select_out,
  output logic             input_ground_out,
  output logic             reference_select_out,
  output logic             trigger_out,
  output logic             irq_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  cmpev_edge_if    raw_edge ();
  logic [15:0]     ctrl_q;
  logic            result_q;
  logic            result_d;
  logic            evt_q;
  logic            evt_set;
  logic            evt_clr;
  logic            irq_st_q;
  logic            irq_msk_q;
  logic            wr_en;
  logic            rd_en;
  logic [31:0]     rdata_d;
  logic            addr_err;
  logic [15:0]     shared_stat;
  logic [1:0]      chan_sel;
  cmpev_edge_type  edge_sel;
  logic            comp_en;
  logic            pol;
  logic            adj_rise;
  logic            adj_fall;

  // Shared decode of whether a register offset is mapped
  function automatic logic is_mapped(input logic [11:0] a);
    if (a == CMPEV_CTRL_OFF) begin
      is_mapped = 1'b1;
    end else if (a == CMPEV_STAT_OFF) begin
      is_mapped = 1'b1;
    end else if (a == CMPEV_IRQST_OFF) begin
      is_mapped = 1'b1;
    end else if (a == CMPEV_IRQMSK_OFF) begin
      is_mapped = 1'b1;
    end else if (a == CMPEV_INPUT_OFF) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction

  // ****************************************************************
  // APB slave: zero wait states
  // ****************************************************************
  // Answers in the first access cycle; unmapped offsets flag pslverr
  assign pready_out  = 1'b1;
  assign wr_en       = psel_in && penable_in && pwrite_in;
  assign rd_en       = psel_in && penable_in && !pwrite_in;
  assign addr_err    = !is_mapped(paddr_in);
  assign pslverr_out = psel_in && penable_in && addr_err;

  // ****************************************************************
  // Raw result conditioning
  // ****************************************************************
  cmpev_sync u_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    (raw_result_in),
    .edge_out    (raw_edge)
  );

  assign comp_en  = ctrl_q[CMPEV_EN_BIT];
  assign pol      = ctrl_q[CMPEV_POL_BIT];
  assign edge_sel = cmpev_edge_type'(ctrl_q[CMPEV_EDGE_HI:CMPEV_EDGE_LO]);

  // Polarity swaps which raw edge counts as rising
  assign adj_rise = pol ? raw_edge.fall : raw_edge.rise;
  assign adj_fall = pol ? raw_edge.rise : raw_edge.fall;

  // Result held low while the comparator is off
  assign result_d = comp_en & (raw_edge.level ^ pol);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      result_q <= 1'b0;
    end else begin
      result_q <= result_d;
    end
  end

  // ****************************************************************
  // Edge event detection
  // ****************************************************************
  // Decoding only while the flag is clear, so a held flag masks edges
  always_comb begin
    evt_set = 1'b0;
    if (comp_en && !evt_q) begin
      case (edge_sel)
        CMPEV_EDGE_NONE: evt_set = 1'b0;
        CMPEV_EDGE_RISE: evt_set = adj_rise;
        CMPEV_EDGE_FALL: evt_set = adj_fall;
        CMPEV_EDGE_ANY:  evt_set = adj_rise | adj_fall;
        default:         evt_set = 1'b0;
      endcase
    end
  end

  // Software clears the flag by writing zero to its control bit
  assign evt_clr = wr_en && (paddr_in == CMPEV_CTRL_OFF) &&
                   !pwdata_in[CMPEV_EVT_BIT];

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      evt_q <= 1'b0;
    end else if (evt_set) begin
      evt_q <= 1'b1;
    end else if (evt_clr) begin
      evt_q <= 1'b0;
    end
  end

  // One-cycle trigger only on the setting edge; flag blocks repeats
  assign trigger_out = evt_set;

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Bits 9 and 8 are hardware state and are never stored from the bus
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl_q <= CMPEV_CTRL_RST;
    end else if (wr_en && paddr_in == CMPEV_CTRL_OFF) begin
      ctrl_q <= pwdata_in[15:0] & CMPEV_CTRL_WMASK;
    end
  end

  // ****************************************************************
  // Input selection
  // ****************************************************************
  // Missing inputs go to ground rather than float into the core
  assign chan_sel = {ctrl_q[CMPEV_CHHI_BIT], ctrl_q[CMPEV_CHLO_BIT]};
  assign input_select_out     = chan_sel;
  assign reference_select_out = ctrl_q[CMPEV_REF_BIT];
  assign input_ground_out     = !AVAIL_INPUTS[chan_sel];

  // ****************************************************************
  // Output pin
  // ****************************************************************
  // Pin driven only while its enable is set
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      result_pin_out    <= 1'b0;
      result_pin_oe_out <= 1'b0;
    end else begin
      result_pin_out    <= result_d & ctrl_q[CMPEV_OE_BIT];
      result_pin_oe_out <= ctrl_q[CMPEV_OE_BIT];
    end
  end

  // ****************************************************************
  // Shared status
  // ****************************************************************
  // Unit one sits at index 0 and unit two at index 1; this block is
  // unit four and mirrors its own control bits at index 3
  always_comb begin
    shared_stat = 16'h0000;
    shared_stat[CMPEV_UNITS-1:0] = other_result_in;
    shared_stat[CMPEV_STAT_EVT_BASE +: CMPEV_UNITS] = other_event_in;
    shared_stat[CMPEV_UNITS-1] = result_q;
    shared_stat[CMPEV_STAT_EVT_BASE+CMPEV_UNITS-1] = evt_q;
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  // Read of the status register clears it; a new event wins
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_st_q <= 1'b0;
    end else if (evt_set) begin
      irq_st_q <= 1'b1;
    end else if (rd_en && paddr_in == CMPEV_IRQST_OFF) begin
      irq_st_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_msk_q <= 1'b0;
    end else if (wr_en && paddr_in == CMPEV_IRQMSK_OFF) begin
      irq_msk_q <= pwdata_in[CMPEV_IRQ_EVT_BIT];
    end
  end

  assign irq_out = irq_st_q & irq_msk_q;

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rdata_d = CMPEV_ZERO32;
    if (paddr_in == CMPEV_CTRL_OFF) begin
      rdata_d[15:0] = ctrl_q;
      rdata_d[CMPEV_EVT_BIT] = evt_q;
      rdata_d[CMPEV_OUT_BIT] = result_q;
    end else if (paddr_in == CMPEV_STAT_OFF) begin
      rdata_d[15:0] = shared_stat;
    end else if (paddr_in == CMPEV_IRQST_OFF) begin
      rdata_d[CMPEV_IRQ_EVT_BIT] = irq_st_q;
    end else if (paddr_in == CMPEV_IRQMSK_OFF) begin
      rdata_d[CMPEV_IRQ_EVT_BIT] = irq_msk_q;
    end else if (paddr_in == CMPEV_INPUT_OFF) begin
      rdata_d[CMPEV_IRQ_EVT_BIT] = input_ground_out;
    end
  end

  // Read data is combinational over registers so it is valid in the
  // single access cycle; zero outside reads keeps the bus quiet
  assign prdata_out = rd_en ? rdata_d : CMPEV_ZERO32;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seq_flag_set;
    evt_set ##1 evt_q;
  endsequence

  // A stopped comparator neither triggers now nor reports next cycle
  sequence seq_off_quiet;
    !trigger_out ##1 !result_q;
  endsequence

  // Flipping polarity over a steady input must flip the result
  AST_POL_INVERT: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (comp_en && $stable(comp_en) && $changed(pol) &&
     $stable(raw_edge.level)) |=> $changed(result_q))
    else $error("polarity change did not flip result");

  AST_POL_CLEAR: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (comp_en && !pol && $stable(comp_en) && $stable(pol))
      |=> (result_q == $past(raw_edge.level)))
    else $error("non-inverted result wrong");

  AST_POL_SET: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (comp_en && pol && $stable(comp_en) && $stable(pol))
      |=> (result_q == !$past(raw_edge.level)))
    else $error("inverted result wrong");

  AST_EVT_STICKY: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (evt_q && !evt_clr) |=> (evt_q && !trigger_out))
    else $error("event flag dropped or retriggered");

  AST_EVT_SEQ: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    evt_set |-> seq_flag_set)
    else $error("event flag not set after edge");

  AST_UNIT_TWO: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    shared_stat[CMPEV_UNIT_TWO_IDX] == other_result_in[CMPEV_UNIT_TWO_IDX])
    else $error("unit two status wrong");

  AST_UNIT_ONE: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    shared_stat[CMPEV_UNIT_ONE_IDX] == other_result_in[CMPEV_UNIT_ONE_IDX])
    else $error("unit one status wrong");

  AST_MIRROR_OUT: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    shared_stat[CMPEV_UNITS-1] == result_q)
    else $error("shared result not mirrored");

  AST_MIRROR_EVT: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    shared_stat[CMPEV_STAT_EVT_BASE+CMPEV_UNITS-1] == evt_q)
    else $error("shared event not mirrored");

  AST_GROUND: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    input_ground_out == !AVAIL_INPUTS[chan_sel])
    else $error("missing input not grounded");

  AST_EDGE_NONE: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (edge_sel == CMPEV_EDGE_NONE) |-> !trigger_out)
    else $error("event with edges disabled");

  // Re-enabling may legally show a result one cycle later, so only
  // the current trigger and the next registered result are checked
  AST_DISABLED: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    !comp_en |-> seq_off_quiet)
    else $error("disabled comparator active");

  // A software clear with no competing edge drops the flag
  AST_EVT_CLEAR: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (evt_clr && !evt_set) |=> !evt_q)
    else $error("event flag not cleared");

  AST_RISE_ONLY: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    (edge_sel == CMPEV_EDGE_RISE && adj_fall) |-> !trigger_out)
    else $error("falling edge triggered in rise mode");

  AST_PIN_OFF: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    !ctrl_q[CMPEV_OE_BIT] |=> !result_pin_oe_out && !result_pin_out)
    else $error("pin driven while output off");

endmodule // cmpev_top
`default_nettype wire

// ==== sim/tb_comparator_event_control.sv ====
// Self-checking testbench for the comparator event control block.
// Assumes the design package, edge interface and modules are compiled
// first; the bench is the only APB master and drives the raw result.
`timescale 1ns/1ps
`default_nettype none
module tb_comparator_event_control
  import cmpev_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        core_clk_in     = 1'b0;
  logic        reset_in        = 1'b1;
  logic        psel_in         = 1'b0;
  logic        penable_in      = 1'b0;
  logic        pwrite_in       = 1'b0;
  logic [11:0] paddr_in        = 12'h000;
  logic [31:0] pwdata_in       = 32'h0000_0000;
  logic        raw_result_in   = 1'b0;
  logic [3:0]  other_result_in = 4'h5;
  logic [3:0]  other_event_in  = 4'h6;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        result_pin_out;
  logic        result_pin_oe_out;
  logic [1:0]  input_select_out;
  logic        input_ground_out;
  logic        reference_select_out;
  logic        trigger_out;
  logic        irq_out;
  int          error_cnt       = 0;
  int          n_checks        = 0;
  logic [31:0] trig_cnt        = 32'h0000_0000;
  logic [31:0] rd_v;
  logic [31:0] t0;
  logic [31:0] cv;
  logic        err_v;
  logic        x;
  logic        f;
  logic [1:0]  mb;

  // Clock: 50 ns period
  always #25 core_clk_in = ~core_clk_in;

  // Channel 3 left unbonded so the grounding path is reachable
  cmpev_top #(.AVAIL_INPUTS(4'h7)) dut (
    .core_clk_in          (core_clk_in),
    .reset_in             (reset_in),
    .psel_in              (psel_in),
    .penable_in           (penable_in),
    .pwrite_in            (pwrite_in),
    .paddr_in             (paddr_in),
    .pwdata_in            (pwdata_in),
    .prdata_out           (prdata_out),
    .pready_out           (pready_out),
    .pslverr_out          (pslverr_out),
    .raw_result_in        (raw_result_in),
    .other_result_in      (other_result_in),
    .other_event_in       (other_event_in),
    .result_pin_out       (result_pin_out),
    .result_pin_oe_out    (result_pin_oe_out),
    .input_select_out     (input_select_out),
    .input_ground_out     (input_ground_out),
    .reference_select_out (reference_select_out),
    .trigger_out          (trigger_out),
    .irq_out              (irq_out)
  );

  // Count trigger pulses; a pulse lasts one cycle so sample every edge
  always @(posedge core_clk_in) begin
    if (trigger_out === 1'b1) trig_cnt <= trig_cnt + 32'h0000_0001;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge core_clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    @(posedge core_clk_in);
    while (pready_out !== 1'b1) @(posedge core_clk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd_v, err_v);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, rd_v, err_v);
    check(nm, rd_v, exp);
  endtask

  // Sync path plus flag update fits well inside eight cycles
  task automatic w8();
    repeat (8) @(posedge core_clk_in);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (5) @(posedge core_clk_in);
    reset_in <= 1'b0;
    // Reset values and shared status from the other units
    rd_chk("ctrl_rst", CMPEV_CTRL_OFF, 32'h0000_0000);
    rd_chk("stat_rst", CMPEV_STAT_OFF, 32'h0000_0605);
    rd_chk("irq_rst", CMPEV_IRQST_OFF, 32'h0000_0000);
    // Unmapped place: error flag, zero data, write dropped
    xfer(1'b1, 12'h020, 32'h0000_FFFF, rd_v, err_v);
    check("slverr_w", {31'h0, err_v}, 32'h0000_0001);
    xfer(1'b0, 12'h020, 32'h0000_0000, rd_v, err_v);
    check("slverr_r", {31'h0, err_v}, 32'h0000_0001);
    check("unmap_rd", rd_v, 32'h0000_0000);
    // Only writable bits stick; channel 3 is not available
    wr(CMPEV_CTRL_OFF, 32'h0000_7FFF);
    rd_chk("ctrl_msk", CMPEV_CTRL_OFF, 32'h0000_60D3);
    check("sel", {30'h0, input_select_out}, 32'h0000_0003);
    check("ref", {31'h0, reference_select_out}, 32'h0000_0001);
    check("gnd", {31'h0, input_ground_out}, 32'h0000_0001);
    rd_chk("gnd_reg", CMPEV_INPUT_OFF, 32'h0000_0001);
    check("oe_on", {31'h0, result_pin_oe_out}, 32'h0000_0001);
    // Disabled unit reports nothing even with inversion set
    raw_result_in <= 1'b1;
    w8();
    rd_chk("disabled", CMPEV_CTRL_OFF, 32'h0000_60D3);
    wr(CMPEV_CTRL_OFF, 32'h0000_0000);
    // The write lands on the access edge; look one edge later
    @(posedge core_clk_in);
    check("gnd_off", {31'h0, input_ground_out}, 32'h0000_0000);
    // Polarity against every raw level, pin and shared mirror
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 2; r++) begin
        raw_result_in <= r[0];
        cv = 32'h0000_C000 | (32'(p) << CMPEV_POL_BIT);
        wr(CMPEV_CTRL_OFF, cv);
        w8();
        x = r[0] ^ p[0];
        cv = cv | (32'(x) << CMPEV_OUT_BIT);
        rd_chk("pol", CMPEV_CTRL_OFF, cv);
        check("pin", {31'h0, result_pin_out}, {31'h0, x});
        rd_chk("mirror", CMPEV_STAT_OFF, 32'h0605 | (32'(x) << 3));
      end
    end
    // Output enable off keeps the pin quiet while result is high
    wr(CMPEV_CTRL_OFF, 32'h0000_8000);
    w8();
    check("pin_off", {31'h0, result_pin_out}, 32'h0000_0000);
    check("oe_off", {31'h0, result_pin_oe_out}, 32'h0000_0000);
    // Every edge mode: one event at most, flag sticky until cleared
    wr(CMPEV_IRQMSK_OFF, 32'h0000_0001);
    for (int m = 0; m < 4; m++) begin
      mb = m[1:0];
      raw_result_in <= 1'b0;
      wr(CMPEV_CTRL_OFF, 32'h0000_8000);
      w8();
      cv = 32'h0000_8000 | (32'(mb) << CMPEV_EDGE_LO);
      wr(CMPEV_CTRL_OFF, cv);
      xfer(1'b0, CMPEV_IRQST_OFF, 32'h0000_0000, rd_v, err_v);
      t0 = trig_cnt;
      raw_result_in <= 1'b1;
      w8();
      rd_chk("evt_rise", CMPEV_CTRL_OFF,
             cv | 32'h0100 | (32'(mb[0]) << 9));
      rd_chk("evt_mir", CMPEV_STAT_OFF,
             32'h060D | (32'(mb[0]) << 11));
      raw_result_in <= 1'b0;
      w8();
      f = (mb != 2'b00);
      rd_chk("evt_fall", CMPEV_CTRL_OFF, cv | (32'(f) << 9));
      check("trig", trig_cnt - t0, {31'h0, f});
      check("irq", {31'h0, irq_out}, {31'h0, f});
      rd_chk("irq_st", CMPEV_IRQST_OFF, {31'h0, f});
      rd_chk("irq_clr", CMPEV_IRQST_OFF, 32'h0000_0000);
      check("irq_low", {31'h0, irq_out}, 32'h0000_0000);
    end
    // Masked event still lands in status but not on the line
    wr(CMPEV_IRQMSK_OFF, 32'h0000_0000);
    wr(CMPEV_CTRL_OFF, 32'h0000_8040);
    raw_result_in <= 1'b1;
    w8();
    check("irq_mask", {31'h0, irq_out}, 32'h0000_0000);
    rd_chk("irq_mst", CMPEV_IRQST_OFF, 32'h0000_0001);
    // New neighbour values must reach the shared status unchanged
    other_result_in <= 4'h2;
    other_event_in  <= 4'h1;
    rd_chk("unit_swp", CMPEV_STAT_OFF, 32'h0000_090A);
    tally_and_finish();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb_comparator_event_control
`default_nettype wire
